//--- src/temp_limit_interrupt_modes.sv
`timescale 1ns/1ps
`default_nettype none
module temp_limit_interrupt_modes (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             INT_N,
   output logic             IRQ
);
   typedef struct packed {
      logic [7:0]  mask_two;
      logic [7:0]  alarm_limit;
      logic [7:0]  hot_limit;
      logic [7:0]  hyst_limit;
      logic [7:0]  temp;
      logic [1:0]  irq_mask;
      logic [1:0]  irq_status;
      logic        alarm_flag;
      logic        hot_flag;
      logic        alarm_tripped;
      logic        hot_tripped;
      logic [15:0] conv_cnt;
      logic        conv_done;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        int_n;
      logic        irq;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // one comparison: returns {set_flag, tripped_next}
   function automatic logic [1:0] eval_limit(input logic oneshot, input logic tripped,
                                             input logic [7:0] t, input logic [7:0] lim,
                                             input logic [7:0] hyst);
      logic above;
      logic below;
      logic [1:0] r;
      above = (t > lim);
      below = (t < hyst);
      r = {1'b0, tripped};
      if (above && !tripped) begin
         r = 2'b11;
      end else if (below && tripped) begin
         r = {oneshot, 1'b0};
      end else if (tripped && !oneshot) begin
         r = 2'b11;
      end
      return r;
   endfunction

   logic       access;
   logic       rd_status;
   logic [1:0] a_res;
   logic [1:0] h_res;
   logic [7:0] status_two;

   assign access     = PSEL && PENABLE && !s_reg.pready;
   assign rd_status  = access && !PWRITE && (PADDR == temp_irq_pkg::STATUS_TWO_OFF);
   assign a_res      = eval_limit(s_reg.mask_two[temp_irq_pkg::ALARM_MODE_BIT], s_reg.alarm_tripped,
                                  s_reg.temp, s_reg.alarm_limit, s_reg.hyst_limit);
   assign h_res      = eval_limit(s_reg.mask_two[temp_irq_pkg::HOT_MODE_BIT], s_reg.hot_tripped,
                                  s_reg.temp, s_reg.hot_limit, s_reg.hyst_limit);

   always_comb begin
      status_two = 8'h00;
      status_two[temp_irq_pkg::ALARM_BIT] = s_reg.alarm_flag;
      status_two[temp_irq_pkg::HOT_BIT]   = s_reg.hot_flag;
   end

   always_comb begin
      s_next = s_reg;
      s_next.pready  = access;
      s_next.pslverr = 1'b0;
      s_next.conv_done = 1'b0;
      if (s_reg.conv_cnt == 16'(temp_irq_pkg::CONV_CYCLES - 1)) begin
         s_next.conv_cnt  = 16'h0000;
         s_next.conv_done = 1'b1;
      end else begin
         s_next.conv_cnt = s_reg.conv_cnt + 16'h0001;
      end
      if (rd_status) begin
         s_next.alarm_flag = 1'b0;
         s_next.hot_flag   = 1'b0;
      end
      if (access) begin
         s_next.prdata = 32'h0000_0000;
         if (PWRITE) begin
            case (PADDR)
               temp_irq_pkg::MASK_TWO_OFF: s_next.mask_two = PWDATA[7:0];
               temp_irq_pkg::LIMITS_OFF: begin
                  s_next.alarm_limit = PWDATA[7:0];
                  s_next.hot_limit   = PWDATA[15:8];
                  s_next.hyst_limit  = PWDATA[23:16];
               end
               temp_irq_pkg::TEMP_OFF: s_next.temp = PWDATA[7:0];
               temp_irq_pkg::IRQ_MASK_OFF: s_next.irq_mask = PWDATA[1:0];
               temp_irq_pkg::STATUS_TWO_OFF: ;
               default: s_next.pslverr = 1'b1;
            endcase
         end else begin
            case (PADDR)
               temp_irq_pkg::STATUS_TWO_OFF: s_next.prdata = {24'h000000, status_two};
               temp_irq_pkg::MASK_TWO_OFF: s_next.prdata = {24'h000000, s_reg.mask_two};
               temp_irq_pkg::LIMITS_OFF: s_next.prdata = {8'h00, s_reg.hyst_limit, s_reg.hot_limit,
                                                          s_reg.alarm_limit};
               temp_irq_pkg::TEMP_OFF: s_next.prdata = {24'h000000, s_reg.temp};
               temp_irq_pkg::IRQ_MASK_OFF: begin
                  s_next.prdata = {28'h0000000, s_reg.irq_mask, s_reg.irq_status};
                  s_next.irq_status = 2'b00;
               end
               default: s_next.pslverr = 1'b1;
            endcase
         end
      end
      // evaluation only at conversion end; set wins over read clear
      if (s_reg.conv_done) begin
         s_next.alarm_tripped = a_res[0];
         s_next.hot_tripped   = h_res[0];
         if (a_res[1]) begin
            s_next.alarm_flag = 1'b1;
            s_next.irq_status[1] = 1'b1;
         end
         if (h_res[1]) begin
            s_next.hot_flag = 1'b1;
            s_next.irq_status[0] = 1'b1;
         end
      end
      s_next.int_n = !((s_next.alarm_flag && !s_next.mask_two[temp_irq_pkg::ALARM_BIT]) ||
                       (s_next.hot_flag && !s_next.mask_two[temp_irq_pkg::HOT_BIT]));
      s_next.irq = |(s_next.irq_status & ~s_next.irq_mask);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s_reg <= '0;
         s_reg.mask_two    <= temp_irq_pkg::MASK_TWO_RST;
         s_reg.alarm_limit <= temp_irq_pkg::ALARM_LIMIT_RST;
         s_reg.hot_limit   <= temp_irq_pkg::HOT_LIMIT_RST;
         s_reg.hyst_limit  <= temp_irq_pkg::HYST_LIMIT_RST;
         s_reg.irq_mask    <= temp_irq_pkg::IRQ_MASK_RST;
         s_reg.int_n       <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA  = s_reg.prdata;
   assign PREADY  = s_reg.pready;
   assign PSLVERR = s_reg.pslverr;
   assign INT_N   = s_reg.int_n;
   assign IRQ     = s_reg.irq;

   sequence conv_rise_alarm;
      s_reg.conv_done && (s_reg.temp > s_reg.alarm_limit) && !s_reg.alarm_tripped;
   endsequence

   a_alarm_rise_flag: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_alarm |=> s_reg.alarm_flag && s_reg.alarm_tripped)
      else $error("alarm flag not set on crossing");
   a_alarm_repeat: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done && !s_reg.mask_two[7] && (s_reg.temp > s_reg.alarm_limit) |=> s_reg.alarm_flag)
      else $error("repeating alarm not re-raised");
   a_alarm_oneshot: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done && s_reg.mask_two[7] && s_reg.alarm_tripped && !rd_status && !s_reg.alarm_flag
      && (s_reg.temp >= s_reg.hyst_limit) |=> !s_reg.alarm_flag)
      else $error("one-time alarm raised again");
   a_hot_repeat: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done && !s_reg.mask_two[6] && (s_reg.temp > s_reg.hot_limit) |=> s_reg.hot_flag)
      else $error("repeating hot not re-raised");
   a_hot_fall: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done && s_reg.mask_two[6] && s_reg.hot_tripped && (s_reg.temp < s_reg.hyst_limit)
      |=> s_reg.hot_flag && !s_reg.hot_tripped)
      else $error("one-time hot fall flag missing");
   a_hot_oneshot: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done && s_reg.mask_two[6] && s_reg.hot_tripped && !s_reg.hot_flag && !rd_status
      && (s_reg.temp >= s_reg.hyst_limit) |=> !s_reg.hot_flag)
      else $error("one-time hot raised again");
   a_read_clears: assert property (@(posedge CLK) disable iff (RST)
      rd_status && !s_reg.conv_done |=> !s_reg.alarm_flag && !s_reg.hot_flag)
      else $error("status read did not clear");
   a_mask_gate: assert property (@(posedge CLK) disable iff (RST)
      s_reg.alarm_flag && !s_reg.mask_two[5] |-> !INT_N)
      else $error("unmasked alarm not on pin");
   a_conv_period: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done |=> !s_reg.conv_done [*8])
      else $error("conversion strobe too close");
   a_mode_reset: assert property (@(posedge CLK)
      $fell(RST) |-> s_reg.mask_two[7:6] == 2'b00)
      else $error("mode bits not zero after reset");

   // helper sequences for the multi-step checks below
   sequence conv_rise_hot;
      s_reg.conv_done && (s_reg.temp > s_reg.hot_limit) && !s_reg.hot_tripped;
   endsequence

   sequence conv_fall_alarm;
      s_reg.conv_done && s_reg.mask_two[temp_irq_pkg::ALARM_MODE_BIT] && s_reg.alarm_tripped
      && (s_reg.temp < s_reg.hyst_limit);
   endsequence

   sequence conv_quiet_alarm;
      s_reg.conv_done && s_reg.mask_two[temp_irq_pkg::ALARM_MODE_BIT] && !s_reg.alarm_tripped
      && (s_reg.temp <= s_reg.alarm_limit);
   endsequence

   sequence conv_quiet_hot;
      s_reg.conv_done && s_reg.mask_two[temp_irq_pkg::HOT_MODE_BIT] && !s_reg.hot_tripped
      && (s_reg.temp <= s_reg.hot_limit);
   endsequence

   sequence status_taken;
      rd_status && !s_reg.conv_done;
   endsequence

   sequence bus_taken;
      PSEL && PENABLE && !PREADY;
   endsequence

   // edges of the one-time modes
   a_hot_rise_flag: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_hot |=> s_reg.hot_flag && s_reg.hot_tripped)
      else $error("hot flag not set on crossing");

   a_alarm_fall: assert property (@(posedge CLK) disable iff (RST)
      conv_fall_alarm |=> s_reg.alarm_flag && !s_reg.alarm_tripped)
      else $error("one-time alarm fall flag missing");

   a_alarm_rearm: assert property (@(posedge CLK) disable iff (RST)
      conv_quiet_alarm and !rd_status && !s_reg.alarm_flag |=> !s_reg.alarm_flag)
      else $error("disarmed alarm raised below limit");

   a_hot_rearm: assert property (@(posedge CLK) disable iff (RST)
      conv_quiet_hot and !rd_status && !s_reg.hot_flag |=> !s_reg.hot_flag)
      else $error("disarmed hot raised below limit");

   // flags still record events while masked from the pin
   a_alarm_masked_rec: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_alarm and s_reg.mask_two[temp_irq_pkg::ALARM_BIT] |=> s_reg.alarm_flag)
      else $error("masked alarm not recorded");

   a_hot_masked_rec: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_hot and s_reg.mask_two[temp_irq_pkg::HOT_BIT] |=> s_reg.hot_flag)
      else $error("masked hot not recorded");

   a_hot_mask_gate: assert property (@(posedge CLK) disable iff (RST)
      s_reg.hot_flag && !s_reg.mask_two[temp_irq_pkg::HOT_BIT] |-> !INT_N)
      else $error("unmasked hot not on pin");

   a_pin_idle: assert property (@(posedge CLK) disable iff (RST)
      !(s_reg.alarm_flag && !s_reg.mask_two[temp_irq_pkg::ALARM_BIT])
      && !(s_reg.hot_flag && !s_reg.mask_two[temp_irq_pkg::HOT_BIT]) |-> INT_N)
      else $error("pin low with no unmasked flag");

   // set wins over a clearing read in the same cycle
   a_alarm_set_wins: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_alarm and rd_status |=> s_reg.alarm_flag)
      else $error("alarm set lost to read clear");

   a_hot_set_wins: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_hot and rd_status |=> s_reg.hot_flag)
      else $error("hot set lost to read clear");

   // status register contents on a read, and unchanged by a write
   a_status_data: assert property (@(posedge CLK) disable iff (RST)
      status_taken |=> PREADY && (PRDATA[temp_irq_pkg::ALARM_BIT] == $past(s_reg.alarm_flag))
      && (PRDATA[temp_irq_pkg::HOT_BIT] == $past(s_reg.hot_flag)))
      else $error("status read data wrong");

   a_status_spare: assert property (@(posedge CLK) disable iff (RST)
      status_taken |=> (PRDATA[31:6] == 26'h0000000) && (PRDATA[4:1] == 4'h0))
      else $error("status spare bits not zero");

   a_status_ro: assert property (@(posedge CLK) disable iff (RST)
      access && PWRITE && (PADDR == temp_irq_pkg::STATUS_TWO_OFF) && !s_reg.conv_done
      && !s_reg.alarm_flag && !s_reg.hot_flag |=> !s_reg.alarm_flag && !s_reg.hot_flag)
      else $error("status written by software");

   // flags are set and armed state moves only at conversion end; status reads clear flags
   a_alarm_hold: assert property (@(posedge CLK) disable iff (RST)
      !s_reg.conv_done && !rd_status && s_reg.alarm_flag |=> s_reg.alarm_flag)
      else $error("alarm flag lost between conversions");

   a_hot_hold: assert property (@(posedge CLK) disable iff (RST)
      !s_reg.conv_done && !rd_status && s_reg.hot_flag |=> s_reg.hot_flag)
      else $error("hot flag lost between conversions");

   a_alarm_quiet: assert property (@(posedge CLK) disable iff (RST)
      !s_reg.conv_done && !s_reg.alarm_flag |=> !s_reg.alarm_flag)
      else $error("alarm flag set off conversion");

   a_hot_quiet: assert property (@(posedge CLK) disable iff (RST)
      !s_reg.conv_done && !s_reg.hot_flag |=> !s_reg.hot_flag)
      else $error("hot flag set off conversion");

   a_armed_stable: assert property (@(posedge CLK) disable iff (RST)
      !s_reg.conv_done |=> $stable(s_reg.alarm_tripped) && $stable(s_reg.hot_tripped))
      else $error("armed state changed off conversion");

   a_conv_bound: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_cnt <= 16'(temp_irq_pkg::CONV_CYCLES - 1))
      else $error("conversion counter out of range");

   a_conv_phase: assert property (@(posedge CLK) disable iff (RST)
      s_reg.conv_done |-> s_reg.conv_cnt == 16'h0000)
      else $error("conversion strobe out of phase");

   // bus answer timing, and the irq status bit of an alarm crossing
   a_ready_answer: assert property (@(posedge CLK) disable iff (RST)
      bus_taken |=> PREADY)
      else $error("no ready after taken access");

   a_ready_pulse: assert property (@(posedge CLK) disable iff (RST)
      PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");

   a_error_ready: assert property (@(posedge CLK) disable iff (RST)
      PSLVERR |-> PREADY)
      else $error("error without ready");

   a_irq_alarm_set: assert property (@(posedge CLK) disable iff (RST)
      conv_rise_alarm |=> s_reg.irq_status[1])
      else $error("alarm event not in irq status");
endmodule
`default_nettype wire

//--- src/temp_irq_pkg.sv
package temp_irq_pkg;
   // register byte offsets (APB, one aligned word each)
   localparam logic [7:0] STATUS_TWO_OFF   = 8'h08;
   localparam logic [7:0] MASK_TWO_OFF     = 8'h10;
   localparam logic [7:0] LIMITS_OFF       = 8'h14;
   localparam logic [7:0] TEMP_OFF         = 8'h18;
   localparam logic [7:0] IRQ_MASK_OFF     = 8'h1C;
   // printed register indices
   localparam logic [7:0] STATUS_TWO_IDX   = 8'h02;
   localparam logic [7:0] MASK_TWO_IDX     = 8'h04;
   // field positions
   localparam int ALARM_BIT                = 5;
   localparam int HOT_BIT                  = 0;
   localparam int ALARM_MODE_BIT           = 7;
   localparam int HOT_MODE_BIT             = 6;
   // reset values
   localparam logic [7:0] MASK_TWO_RST     = 8'h00;
   localparam logic [7:0] ALARM_LIMIT_RST  = 8'h50;
   localparam logic [7:0] HOT_LIMIT_RST    = 8'h46;
   localparam logic [7:0] HYST_LIMIT_RST   = 8'h3C;
   localparam logic [1:0] IRQ_MASK_RST     = 2'h0;
   // conversion period
   localparam int CONV_TIME_US             = 10;
   localparam int CLK_MHZ                  = 50;
   localparam int CONV_CYCLES              = CONV_TIME_US * CLK_MHZ;
endpackage

//--- testbench/apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host (
   input  wire logic        CLK,
   input  wire logic        PREADY,
   input  wire logic [31:0] PRDATA,
   input  wire logic        PSLVERR,
   output logic             PSEL,
   output logic             PENABLE,
   output logic             PWRITE,
   output logic [7:0]       PADDR,
   output logic [31:0]      PWDATA
);
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
   end
   // entered just after a rising edge; request held until pready is sampled high or 50 edges pass
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 50);
      r = PRDATA;
      err = (PREADY === 1'b1) ? PSLVERR : 1'b1;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // let one edge pass so a following call never reassigns psel in this time step
      @(posedge CLK);
   endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        CLK = 1'b0;
   logic        RST = 1'b1;
   logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INT_N, IRQ, err;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   int          fail_count = 0;
   int          checked = 0;
   always #10 CLK = ~CLK;
   temp_limit_interrupt_modes DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .INT_N(INT_N), .IRQ(IRQ));
   apb_host host (.CLK(CLK), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd, err);
      check({31'h0, err}, 32'h0, "write response");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      host.xfer(1'b0, a, 32'h0, rd, err);
      check({rd[31:1], rd[0] ^ err}, exp ^ {31'h0, a == 8'h04}, what);
   endtask
   // one full conversion period plus the flag latency
   task automatic conv;
      repeat (temp_irq_pkg::CONV_CYCLES + 10) @(posedge CLK);
   endtask
   task automatic test_reset;
      rdc(temp_irq_pkg::MASK_TWO_OFF, 32'h0, "mask reset");
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h0, "status reset");
      rdc(8'h04, 32'h0, "unmapped error");
      check({INT_N, IRQ}, 2'b10, "pins after reset");
   endtask
   task automatic test_repeat;
      wr(temp_irq_pkg::TEMP_OFF, 32'h55);
      conv();
      check({INT_N, IRQ}, 2'b01, "pins on trip");
      rdc(temp_irq_pkg::IRQ_MASK_OFF, 32'h3, "irq status");
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "first flags");
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "flags again");
      wr(temp_irq_pkg::MASK_TWO_OFF, 32'h21);
      wr(temp_irq_pkg::IRQ_MASK_OFF, 32'h3);
      rdc(temp_irq_pkg::MASK_TWO_OFF, 32'h21, "mask readback");
      conv();
      check({INT_N, IRQ}, 2'b10, "pins masked");
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "masked flags");
      rdc(temp_irq_pkg::IRQ_MASK_OFF, 32'hF, "irq masked");
      wr(temp_irq_pkg::IRQ_MASK_OFF, 32'h0);
   endtask
   task automatic test_oneshot;
      wr(temp_irq_pkg::MASK_TWO_OFF, 32'hC0);
      wr(temp_irq_pkg::TEMP_OFF, 32'h30);
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "fall after mode change");
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h0, "quiet below");
      wr(temp_irq_pkg::TEMP_OFF, 32'h55);
      conv();
      check(INT_N, 1'b0, "one-time trip pin");
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "one-time trip");
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h0, "no repeat");
      check(INT_N, 1'b1, "pin idle");
      wr(temp_irq_pkg::TEMP_OFF, 32'h30);
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h21, "fall flag");
      conv();
      rdc(temp_irq_pkg::STATUS_TWO_OFF, 32'h0, "after fall");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      test_reset();
      test_repeat();
      test_oneshot();
      finish_test();
   end
endmodule
`default_nettype wire
